// ---- hdl/gtimer_map.svh ----
`ifndef GTIMER_MAP_SVH
`define GTIMER_MAP_SVH
// Register byte offsets
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_ENABLES 8'h0c
`define OFS_FLAGS 8'h10
`define OFS_EVT_GEN 8'h14
`define OFS_MODE_ONE 8'h18
`define OFS_MODE_TWO 8'h1c
`define OFS_OUT_EN 8'h20
`define OFS_COUNT 8'h24
`define OFS_PRESCALE 8'h28
`define OFS_RELOAD 8'h2c
`define OFS_REPEAT 8'h30
`define OFS_CC1 8'h34
`define REG_STRIDE 4
// Field positions
`define F_RUN 0
`define F_UPD_DIS 1
`define F_DIR_LO 5
`define F_PRELOAD 7
`define F_CMP_DMA 3
`define F_UGEN 0
`define F_UFLAG 0
`define F_CH_BASE 1
`define F_UPD_DMA 8
`define F_CH_DMA 9
`define F_CH_EN 0
`define F_CH_POL 1
`define CH_EN_STRIDE 4
`define CFG_BITS 8
// Reset values
`define RST_ZERO 16'h0000
`define RST_RELOAD 16'hffff
// Timing and encodings
`define FILT_LEN 3'd4
`define IO_OUTPUT 2'b00
`define IO_INPUT 2'b01
`endif

// ---- hdl/gtimer_pkg.sv ----
package gtimer_pkg;
  typedef enum logic [1:0] {
    DIR_UP = 2'b00,
    DIR_DOWN = 2'b01,
    DIR_CENTER = 2'b10
  } count_dir_t;
  typedef enum logic [2:0] {
    OC_FREEZE = 3'h0,
    OC_SET_MATCH = 3'h1,
    OC_CLR_MATCH = 3'h2,
    OC_TOGGLE = 3'h3,
    OC_FORCE_LOW = 3'h4,
    OC_FORCE_HIGH = 3'h5,
    OC_PWM_ONE = 3'h6,
    OC_PWM_TWO = 3'h7
  } oc_mode_t;
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;
  typedef struct packed {
    logic spare;
    oc_mode_t mode;
    logic [1:0] icp;
    logic [1:0] io_sel;
  } chan_cfg_t;
endpackage

// ---- hdl/capture_input_cond.sv ----
`timescale 1ns/100ps
`include "gtimer_map.svh"
module capture_input_cond (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Pin and edge choice
  input wire logic i_pin,
  input wire logic i_falling,
  // Qualified edge
  output logic o_event
);
  logic sync1_q;
  logic sync2_q;
  logic level_q;
  logic [2:0] filt_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
    end
  end

  // Level must hold for several cycles, so short glitches never count
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      filt_q <= 3'h0;
      level_q <= 1'b0;
      o_event <= 1'b0;
    end else begin
      o_event <= 1'b0;
      if (sync2_q == level_q) begin
        filt_q <= 3'h0;
      end else if (filt_q == `FILT_LEN - 3'd1) begin
        filt_q <= 3'h0;
        level_q <= sync2_q;
        o_event <= (sync2_q != i_falling);
      end else begin
        filt_q <= filt_q + 3'd1;
      end
    end
  end
endmodule // capture_input_cond

// ---- hdl/prescale_tick.sv ----
`timescale 1ns/100ps
module prescale_tick (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic [15:0] i_ratio,
  // Counter tick
  output logic o_tick
);
  logic [15:0] div_q;

  // Ratio value n divides by n+1, giving 1 to 65536
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      div_q <= 16'h0000;
      o_tick <= 1'b0;
    end else if (i_clear) begin
      // Restart as if a tick had just passed, so an update never costs a cycle
      div_q <= (i_run && i_ratio != 16'h0000) ? 16'h0001 : 16'h0000;
      o_tick <= i_run && i_ratio == 16'h0000;
    end else if (i_run && div_q >= i_ratio) begin
      div_q <= 16'h0000;
      o_tick <= 1'b1;
    end else if (i_run) begin
      div_q <= div_q + 16'h0001;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
    end
  end
endmodule // prescale_tick

// ---- hdl/general_timer_capture_pwm.sv ----
// Functional notes
// - Sixteen-bit counter counting up, down or center-aligned.
// - Direction and center mode come from control-one direction field.
// - Up: from 0, plus one per tick; at reload limit restart at 0, overflow.
// - Down: minus one per tick; at 0 reload limit and underflow.
// - Center: 0 to limit and back; overflow at limit-1 rising, underflow at 1.
// - Overflow makes update event; it loads buffered reload, prescaler, repeat.
// - Update-disable bit suppresses update events.
// - Buffered 16-bit prescaler divides by 1 to 65536, writable while running.
// - Prescaler runs on the internal timer clock.
// - Four independent channels, each with one compare value register.
// - Capture inputs pass edge detection and filtering.
// - Capture prescaler sets events needed per capture.
// - Selected edge latches count, sets channel flag, may interrupt.
// - Compare mode field picks one of eight output behaviours.
// - On match, output goes high, low or toggles, per mode and polarity.
// - Channel flag raises interrupt if enabled, DMA if compare DMA select set.
// - PWM width follows compare value, period follows reload limit.
// - PWM mode 1: active while count below compare value.
// - PWM mode 2: inactive while count below compare value.
// - Force modes fix output; interrupts and DMA still come.
// - Reload write waits for next update when preload on or an update falls in its cycle, else immediate.
// - Counter advances only while run enable is 1.
`timescale 1ns/100ps
`include "gtimer_map.svh"
module general_timer_capture_pwm
  import gtimer_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire avs_req_t i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Channel pins
  input wire logic [3:0] i_cap_pin,
  output logic [3:0] o_ch_out,
  // Requests
  output logic o_irq,
  output logic o_dma_req
);
  bus_state_t bus_q;
  logic [15:0] ctrl1_q;
  logic [15:0] ctrl2_q;
  logic [15:0] dien_q;
  logic [15:0] sts_q;
  logic [15:0] sts_d;
  logic [15:0] ccm1_q;
  logic [15:0] ccm2_q;
  logic [15:0] ccen_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic down_q;
  logic down_d;
  logic [15:0] psc_buf_q;
  logic [15:0] psc_act_q;
  logic [15:0] arr_buf_q;
  logic [15:0] arr_act_q;
  logic [15:0] rep_buf_q;
  logic [15:0] rep_act_q;
  logic [15:0] ccr_q [4];
  logic [31:0] rd_mux;
  logic [31:0] cfg_all;
  logic [3:0] ch_evt;
  logic [3:0] ch_out_d;
  logic run;
  logic tick;
  logic cnt_evt;
  logic ug_write;
  logic uev;
  count_dir_t dir;

  // Write strobe for one register, at the edge where waitrequest is low
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = (bus_q == BUS_ACK) && i_avs.write && (i_avs.address == ofs);
  endfunction

  // Byte lanes 0 and 1 carry the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old);
    merge16[7:0] = i_avs.byteenable[0] ? i_avs.writedata[7:0] : old[7:0];
    merge16[15:8] = i_avs.byteenable[1] ? i_avs.writedata[15:8] : old[15:8];
  endfunction

  assign run = ctrl1_q[`F_RUN];
  assign dir = count_dir_t'(ctrl1_q[`F_DIR_LO +: 2]);
  assign cfg_all = {ccm2_q, ccm1_q};
  // A plain assign would not see the bus signals read inside the function
  always_comb ug_write = wr_hit(`OFS_EVT_GEN) && i_avs.writedata[`F_UGEN];
  assign uev = (cnt_evt || ug_write) && !ctrl1_q[`F_UPD_DIS];

  // Bus handshake: one wait cycle, then a single acknowledge cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      bus_q <= BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else if (bus_q == BUS_IDLE && (i_avs.read || i_avs.write)) begin
      bus_q <= BUS_ACK;
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= i_avs.read ? rd_mux : 32'h0000_0000;
    end else begin
      bus_q <= BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
    end
  end

  // Readback; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_avs.address == `OFS_CTRL_ONE) begin
      rd_mux[15:0] = ctrl1_q;
    end else if (i_avs.address == `OFS_CTRL_TWO) begin
      rd_mux[15:0] = ctrl2_q;
    end else if (i_avs.address == `OFS_ENABLES) begin
      rd_mux[15:0] = dien_q;
    end else if (i_avs.address == `OFS_FLAGS) begin
      rd_mux[15:0] = sts_q;
    end else if (i_avs.address == `OFS_MODE_ONE) begin
      rd_mux[15:0] = ccm1_q;
    end else if (i_avs.address == `OFS_MODE_TWO) begin
      rd_mux[15:0] = ccm2_q;
    end else if (i_avs.address == `OFS_OUT_EN) begin
      rd_mux[15:0] = ccen_q;
    end else if (i_avs.address == `OFS_COUNT) begin
      rd_mux[15:0] = cnt_q;
    end else if (i_avs.address == `OFS_PRESCALE) begin
      rd_mux[15:0] = psc_buf_q;
    end else if (i_avs.address == `OFS_RELOAD) begin
      rd_mux[15:0] = arr_buf_q;
    end else if (i_avs.address == `OFS_REPEAT) begin
      rd_mux[15:0] = rep_act_q;
    end else if (i_avs.address == `OFS_CC1) begin
      rd_mux[15:0] = ccr_q[0];
    end else if (i_avs.address == 8'(`OFS_CC1 + `REG_STRIDE)) begin
      rd_mux[15:0] = ccr_q[1];
    end else if (i_avs.address == 8'(`OFS_CC1 + 2 * `REG_STRIDE)) begin
      rd_mux[15:0] = ccr_q[2];
    end else if (i_avs.address == 8'(`OFS_CC1 + 3 * `REG_STRIDE)) begin
      rd_mux[15:0] = ccr_q[3];
    end
  end

  // Plain control registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl1_q <= `RST_ZERO;
      ctrl2_q <= `RST_ZERO;
      dien_q <= `RST_ZERO;
      ccm1_q <= `RST_ZERO;
      ccm2_q <= `RST_ZERO;
      ccen_q <= `RST_ZERO;
    end else begin
      if (wr_hit(`OFS_CTRL_ONE)) begin
        ctrl1_q <= merge16(ctrl1_q);
      end
      if (wr_hit(`OFS_CTRL_TWO)) begin
        ctrl2_q <= merge16(ctrl2_q);
      end
      if (wr_hit(`OFS_ENABLES)) begin
        dien_q <= merge16(dien_q);
      end
      if (wr_hit(`OFS_MODE_ONE)) begin
        ccm1_q <= merge16(ccm1_q);
      end
      if (wr_hit(`OFS_MODE_TWO)) begin
        ccm2_q <= merge16(ccm2_q);
      end
      if (wr_hit(`OFS_OUT_EN)) begin
        ccen_q <= merge16(ccen_q);
      end
    end
  end

  // Buffered time base values and their active copies
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      psc_buf_q <= `RST_ZERO;
      psc_act_q <= `RST_ZERO;
      arr_buf_q <= `RST_RELOAD;
      arr_act_q <= `RST_RELOAD;
      rep_buf_q <= `RST_ZERO;
      rep_act_q <= `RST_ZERO;
    end else begin
      if (wr_hit(`OFS_PRESCALE)) begin
        psc_buf_q <= merge16(psc_buf_q);
      end
      if (wr_hit(`OFS_RELOAD)) begin
        arr_buf_q <= merge16(arr_buf_q);
      end
      if (wr_hit(`OFS_REPEAT)) begin
        rep_buf_q <= merge16(rep_buf_q);
      end
      if (uev) begin
        psc_act_q <= psc_buf_q;
        arr_act_q <= arr_buf_q;
        rep_act_q <= rep_buf_q;
      end else if (wr_hit(`OFS_RELOAD) && !ctrl1_q[`F_PRELOAD]) begin
        arr_act_q <= merge16(arr_buf_q);
      end
    end
  end

  // Divider fed by the timer's own clock; restarted by each update
  prescale_tick u_prescale (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(run),
    .i_clear(uev),
    .i_ratio(uev ? psc_buf_q : psc_act_q),
    .o_tick(tick)
  );

  // Next count and counter event
  always_comb begin
    cnt_d = cnt_q;
    down_d = down_q;
    cnt_evt = 1'b0;
    if (run && tick) begin
      case (dir)
        DIR_DOWN: begin
          if (cnt_q == 16'h0000) begin
            cnt_d = arr_act_q;
            cnt_evt = 1'b1;
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
        DIR_CENTER: begin
          // A zero limit would wrap, so the counter simply holds
          if (arr_act_q != 16'h0000 && !down_q) begin
            cnt_evt = (cnt_q == arr_act_q - 16'h0001);
            if (cnt_q >= arr_act_q) begin
              down_d = 1'b1;
              cnt_d = cnt_q - 16'h0001;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end else if (arr_act_q != 16'h0000) begin
            cnt_evt = (cnt_q == 16'h0001);
            if (cnt_q == 16'h0000) begin
              down_d = 1'b0;
              cnt_d = 16'h0001;
            end else begin
              cnt_d = cnt_q - 16'h0001;
            end
          end
        end
        default: begin
          // Greater-or-equal copes with an immediate shrink of the limit
          if (cnt_q >= arr_act_q) begin
            cnt_d = 16'h0000;
            cnt_evt = 1'b1;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end
      endcase
    end
  end

  // Counter register; software writes take priority
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_q <= `RST_ZERO;
      down_q <= 1'b0;
    end else if (wr_hit(`OFS_COUNT)) begin
      cnt_q <= merge16(cnt_q);
    end else if (uev && ug_write) begin
      cnt_q <= (dir == DIR_DOWN) ? arr_act_q : `RST_ZERO;
      down_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      down_q <= down_d;
    end
  end

  // Channels
  for (genvar i = 0; i < 4; i++) begin : g_ch
    chan_cfg_t cfg;
    logic en;
    logic pol;
    logic edge_evt;
    logic [2:0] icp_q;
    logic [2:0] icp_last;
    logic cap_fire;
    logic match_q;
    logic cmp_fire;
    logic ref_q;
    logic below;

    assign cfg = chan_cfg_t'(cfg_all[i * `CFG_BITS +: `CFG_BITS]);
    assign en = ccen_q[i * `CH_EN_STRIDE + `F_CH_EN];
    assign pol = ccen_q[i * `CH_EN_STRIDE + `F_CH_POL];
    assign icp_last = 3'((4'h1 << cfg.icp) - 4'h1);
    assign below = (cnt_q < ccr_q[i]);

    capture_input_cond u_cond (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_pin(i_cap_pin[i]),
      .i_falling(pol),
      .o_event(edge_evt)
    );

    assign cap_fire = edge_evt && en && cfg.io_sel == `IO_INPUT && icp_q == icp_last;
    assign cmp_fire = cfg.io_sel == `IO_OUTPUT && !match_q && cnt_q == ccr_q[i];
    assign ch_evt[i] = cap_fire || cmp_fire;

    // Counts qualifying edges, 1, 2, 4 or 8 per capture
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        icp_q <= 3'h0;
      end else if (cfg.io_sel != `IO_INPUT || !en) begin
        icp_q <= 3'h0;
      end else if (edge_evt) begin
        icp_q <= (icp_q == icp_last) ? 3'h0 : icp_q + 3'h1;
      end
    end

    // Capture wins over a software write in the same cycle
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        ccr_q[i] <= `RST_ZERO;
      end else if (cap_fire) begin
        ccr_q[i] <= cnt_q;
      end else if (wr_hit(8'(`OFS_CC1 + i * `REG_STRIDE))) begin
        ccr_q[i] <= merge16(ccr_q[i]);
      end
    end

    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        // Starts matched, so a reset counter at zero gives no false compare event
        match_q <= 1'b1;
        ref_q <= 1'b0;
      end else begin
        match_q <= (cnt_q == ccr_q[i]);
        case (cfg.mode)
          OC_SET_MATCH: ref_q <= cmp_fire ? 1'b1 : ref_q;
          OC_CLR_MATCH: ref_q <= cmp_fire ? 1'b0 : ref_q;
          OC_TOGGLE: ref_q <= cmp_fire ? !ref_q : ref_q;
          OC_FORCE_LOW: ref_q <= 1'b0;
          OC_FORCE_HIGH: ref_q <= 1'b1;
          OC_PWM_ONE: ref_q <= below;
          OC_PWM_TWO: ref_q <= !below;
          default: ref_q <= ref_q;
        endcase
      end
    end

    assign ch_out_d[i] = en && cfg.io_sel == `IO_OUTPUT && (ref_q ^ pol);
  end

  // Flags: hardware set wins over a write-zero clear
  always_comb begin
    sts_d = wr_hit(`OFS_FLAGS) ? (sts_q & i_avs.writedata[15:0]) : sts_q;
    sts_d[`F_UFLAG] = sts_d[`F_UFLAG] || uev;
    sts_d[`F_CH_BASE +: 4] = sts_d[`F_CH_BASE +: 4] | ch_evt;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sts_q <= `RST_ZERO;
    end else begin
      sts_q <= sts_d & 16'h001f;
    end
  end

  // Pins and requests, all from flip-flops
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_ch_out <= 4'h0;
      o_irq <= 1'b0;
      o_dma_req <= 1'b0;
    end else begin
      o_ch_out <= ch_out_d;
      o_irq <= |(sts_q[4:0] & dien_q[4:0]);
      if (ctrl2_q[`F_CMP_DMA]) begin
        o_dma_req <= |(ch_evt & dien_q[`F_CH_DMA +: 4]);
      end else begin
        o_dma_req <= uev && dien_q[`F_UPD_DMA];
      end
    end
  end
endmodule // general_timer_capture_pwm

// ---- tb/cap_pin_model.sv ----
`timescale 1ns/100ps
module cap_pin_model (
  // Clock
  input wire logic i_ref_clk,
  // Commands from the bench
  input wire logic [3:0] i_fire,
  input wire logic [7:0] i_width,
  // Pins, low between pulses
  output logic [3:0] o_pin
);
  int left [4] = '{0, 0, 0, 0};
  initial o_pin = 4'h0;
  // Short widths probe the filter, long ones give one clean edge pair
  always @(posedge i_ref_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (i_fire[k]) left[k] = i_width;
      else if (left[k] > 0) left[k] = left[k] - 1;
      o_pin[k] <= left[k] > 0;
    end
  end
endmodule // cap_pin_model

// ---- tb/gtimer_checker.sv ----
`timescale 1ns/100ps
module gtimer_checker
  import gtimer_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Watched ports
  input wire avs_req_t i_avs,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [3:0] i_cap_pin,
  input wire logic [3:0] o_ch_out,
  input wire logic o_irq,
  input wire logic o_dma_req
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic req;
  assign req = i_avs.read | i_avs.write;
  property p_ack_next;
    req && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered");
  property p_ack_one;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("answer too long");
  property p_no_ack_idle;
    !req |=> o_avs_waitrequest;
  endproperty
  a_no_ack_idle: assert property (p_no_ack_idle) else $error("answer without request");
  property p_hold_data;
    o_avs_waitrequest |-> $stable(o_avs_readdata);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("read data moved");
  property p_unmapped;
    i_avs.read && o_avs_waitrequest && i_avs.address == 8'h08 |=> o_avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_upper_zero;
    !o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  property p_dma_pulse;
    o_dma_req |=> !o_dma_req;
  endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("dma pulse too long");
  property p_reset_quiet;
    $fell(i_rst) |-> o_avs_waitrequest && o_ch_out == 4'h0 && !o_irq && !o_dma_req;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule // gtimer_checker
bind general_timer_capture_pwm gtimer_checker gtimer_checker_i (.i_ref_clk, .i_rst, .i_avs,
  .o_avs_readdata, .o_avs_waitrequest, .i_cap_pin, .o_ch_out, .o_irq, .o_dma_req);

// ---- tb/general_timer_capture_pwm_test.sv ----
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module general_timer_capture_pwm_test;
  import gtimer_pkg::*;
  logic clk;
  logic rst;
  avs_req_t avs;
  logic [31:0] rdata;
  logic wreq;
  logic [3:0] cap_pin;
  logic [3:0] ch_out;
  logic irq;
  logic dma;
  logic [3:0] fire;
  logic [7:0] width;
  logic [31:0] seed = 32'h1a896c7d;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int hi [4] = '{0, 0, 0, 0};
  int h0 [4];
  int cc [4];
  int ev_q [$];
  int tbl [11] = '{12'h040, 12'h000, 12'h010, 12'h020, 12'h030, 12'h050, 12'h060, 12'h070,
    12'h061, 12'h160, 12'h260};
  general_timer_capture_pwm general_timer_capture_pwm_i (
    .i_ref_clk(clk),
    .i_rst(rst),
    .i_avs(avs),
    .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq),
    .i_cap_pin(cap_pin),
    .o_ch_out(ch_out),
    .o_irq(irq),
    .o_dma_req(dma)
  );
  cap_pin_model cap_pin_model_i (.i_ref_clk(clk), .i_fire(fire), .i_width(width), .o_pin(cap_pin));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // Falling edge sampling keeps the tallies clear of edge races
  always @(negedge clk) begin
    for (int k = 0; k < 4; k++) hi[k] += (ch_out[k] === 1'b1);
    if (dma === 1'b1) ev_q.push_back(cyc);
  end
  always @(posedge clk) begin
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Cycles between update events
  function automatic int gap(int d, int r, int p);
    return (d == 2) ? r * (p + 1) : (r + 1) * (p + 1);
  endfunction
  // High cycles of one channel over two periods, one in center mode, reload 9, divide by 1
  function automatic int high2(int d, int m, int c, int pl);
    int w;
    int p1;
    int h;
    w = 2 * gap(d, 9, 0);
    p1 = (d == 2) ? 2 * c - 1 : 2 * c;
    case (m)
      1, 5: h = w;
      3: h = w / 2;
      6: h = p1;
      7: h = w - p1;
      default: h = 0;
    endcase
    return pl ? w - h : h;
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    // Only the bench timeout ends a wait for the answer
    @(posedge clk);
    avs <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    avs <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  // Stop, load buffers by software update, check the restart value, run
  task automatic start(int d, int r, int p);
    logic [31:0] q;
    wr(8'h00, d << 5);
    wr(8'h28, p);
    wr(8'h2c, r);
    wr(8'h14, 32'h1);
    rd(8'h24, q);
    `CHK("restart count", (d == 1) ? r : 0, q);
    wr(8'h00, 32'h81 | (d << 5));
  endtask
  task automatic events(int p, int d, int r);
    ev_q.delete();
    while (ev_q.size() < 5) begin
      @(posedge clk);
    end
    `CHK("update gap", gap(d, r, p), ev_q[4] - ev_q[3]);
    `CHK("update gap", gap(d, r, p), ev_q[3] - ev_q[2]);
  endtask
  task automatic pulse(logic [3:0] m, logic [7:0] w);
    @(posedge clk);
    width <= w;
    fire <= m;
    @(posedge clk);
    fire <= 4'h0;
  endtask
  initial begin
    logic [31:0] q;
    logic [31:0] v;
    int d;
    int r;
    int p;
    int m;
    int pl;
    avs = '0;
    fire = 4'h0;
    width = 8'd8;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a <= 12'h044; a += 4) begin
      rd(8'(a), q);
      `CHK("reset value", (a == 12'h02c) ? 32'hffff : 32'h0, q);
    end
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      cc[k] = seed[15:0];
      wr(8'(8'h34 + 4 * k), seed);
    end
    for (int k = 0; k < 4; k++) begin
      rd(8'(8'h34 + 4 * k), q);
      `CHK("compare value", cc[k], q);
    end
    wr(8'h0c, 32'h100);
    for (d = 0; d < 3; d++) begin
      seed = lfsr(seed);
      r = 4 + seed[3:0] % 12;
      p = seed[9:8];
      start(d, r, p);
      events(p, d, r);
    end
    // Ratio change while running lands at the next update
    wr(8'h28, 32'h3);
    events(3, 2, r);
    wr(8'h00, 32'hc3);
    repeat (3) @(posedge clk);
    ev_q.delete();
    repeat (200) @(posedge clk);
    `CHK("events while disabled", 0, ev_q.size());
    wr(8'h00, 32'hc1);
    wr(8'h0c, 32'h101);
    repeat (3) @(posedge clk);
    `CHK("update irq", 1'b1, irq);
    wr(8'h00, 32'h0);
    rd(8'h24, v);
    wr(8'h10, 32'h0);
    repeat (50) @(posedge clk);
    rd(8'h24, q);
    `CHK("stopped count", v, q);
    `CHK("irq cleared", 1'b0, irq);
    wr(8'h0c, 32'h0);
    for (int k = 0; k < 4; k++) wr(8'(8'h34 + 4 * k), 2 + 2 * k);
    for (int i = 0; i < 11; i++) begin
      d = tbl[i] >> 8;
      m = (tbl[i] >> 4) & 7;
      pl = tbl[i] & 1;
      wr(8'h20, pl ? 32'h3333 : 32'h1111);
      wr(8'h18, (m << 4) | (m << 12));
      wr(8'h1c, (m << 4) | (m << 12));
      start(d, 9, 0);
      repeat (24) @(posedge clk);
      for (int k = 0; k < 4; k++) h0[k] = hi[k];
      repeat (2 * gap(d, 9, 0)) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
        `CHK("high cycles", high2(d, m, 2 + 2 * k, pl), hi[k] - h0[k]);
      end
    end
    wr(8'h00, 32'h0);
    wr(8'h20, 32'h0031);
    wr(8'h18, 32'h0501);
    wr(8'h04, 32'h8);
    wr(8'h0c, 32'h206);
    wr(8'h10, 32'h0);
    for (int j = 0; j < 2; j++) begin
      seed = lfsr(seed);
      v = {17'h1, seed[14:0]};
      wr(8'h24, v);
      pulse(4'h1, 8'd2);
      repeat (20) @(posedge clk);
      ev_q.delete();
      pulse(4'h3, 8'd8);
      repeat (30) @(posedge clk);
      rd(8'h34, q);
      `CHK("capture value", v, q);
      rd(8'h10, q);
      `CHK("capture flags", j ? 32'h6 : 32'h2, q);
      `CHK("capture irq", 1'b1, irq);
      `CHK("capture dma", 1, ev_q.size());
    end
    rd(8'h38, q);
    `CHK("second edge capture", v, q);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h2c, q);
    `CHK("reload after reset", 32'hffff, q);
    `CHK("irq after reset", 1'b0, irq);
    test_done();
  end
endmodule // general_timer_capture_pwm_test
